// ==== src/ind_monitor_defs.vh ====
// constants for the indicator position monitor
`ifndef IND_MONITOR_DEFS_VH
`define IND_MONITOR_DEFS_VH

// ----------------------------------------
// instances and states
// ----------------------------------------
`define N_INST 10
`define ST_INTER 2'h0
`define ST_OPEN 2'h1
`define ST_CLOSE 2'h2
`define ST_BAD 2'h3

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATE 8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_MASK 8'h0C
`define ADDR_TIME 8'h10
`define ADDR_CFG_BASE 8'h20
`define ADDR_CFG_LAST 8'h44

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_RUN 0
`define CFG_OPEN_SRC 0
`define CFG_CLOSE_SRC 1
`define CFG_SINGLE 2
`define CFG_FILT_LSB 4
`define CFG_RESET 12'hFF0
`define IRQ_EVENT 0
`define IRQ_BAD 1
`define IRQ_OVERRUN 2
`define IRQ_MASK_RESET 3'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define STAMP_RES_NS 1000000
`define MS_CYCLES (`STAMP_RES_NS / `CLK_PERIOD_NS)

`endif

// ==== src/ind_monitor.v ====
// indicator position monitor, ten instances, event emitter and register port
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ind_monitor_defs.vh"

module ind_monitor #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // clock, reset, enable
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  // digital input pins, asynchronous
  input wire [9:0] open_pin,
  input wire [9:0] close_pin,
  // internal logic signals, same clock
  input wire [9:0] open_user_selected_signal,
  input wire [9:0] close_user_selected_signal,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // decoded state, two bits per instance
  output reg [19:0] state_ff,
  // event stream towards the common event buffer
  output reg ev_valid_ff,
  output reg [3:0] ev_inst_ff,
  output reg [1:0] ev_code_ff,
  output reg ev_on_ff,
  output reg [31:0] ev_stamp_ff,
  // interrupt
  output reg irq_ff
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [9:0] open_s1_ff;
  reg [9:0] open_s2_ff;
  reg [9:0] close_s1_ff;
  reg [9:0] close_s2_ff;
  reg run_ff;
  reg [11:0] cfg_ff [0:9];
  reg [39:0] prev_ff;
  reg [39:0] pend_ff;
  reg [39:0] lvl_ff;
  reg [31:0] stamp_ff [0:9];
  reg [31:0] ms_cnt_ff;
  reg [31:0] tick_cnt_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_mask_ff;

  // ----------------------------------------
  // combinational values
  // ----------------------------------------
  reg [31:0] nxt_rdata;
  reg [39:0] nxt_pend;
  reg [39:0] clr;
  reg [5:0] win;
  reg found;
  reg [2:0] irq_set;
  reg rd_irq;
  integer k;

  // ----------------------------------------
  // nets
  // ----------------------------------------
  wire [39:0] st;
  wire [39:0] keep;
  wire [19:0] nxt_state;
  wire [39:0] chg;
  wire [39:0] set;
  wire [9:0] inst_hit;
  wire cfg_wr;
  wire cfg_hit;
  wire [7:0] cfg_off;
  wire [3:0] cfg_idx;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      open_s1_ff <= 10'h000;
      open_s2_ff <= 10'h000;
      close_s1_ff <= 10'h000;
      close_s2_ff <= 10'h000;
    end else if (ce) begin
      // first flop feeds only the second
      open_s1_ff <= open_pin;
      open_s2_ff <= open_s1_ff;
      close_s1_ff <= close_pin;
      close_s2_ff <= close_s1_ff;
    end
  end

  // ----------------------------------------
  // per instance source select and decode
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `N_INST; i = i + 1) begin : g_inst
      wire so;
      wire sc_raw;
      wire sc;
      wire [11:0] c;
      assign c = cfg_ff[i];
      // open level, 1 means open
      assign so = c[`CFG_OPEN_SRC] ? open_user_selected_signal[i] : open_s2_ff[i];
      // close level, 1 means closed
      assign sc_raw = c[`CFG_CLOSE_SRC] ? close_user_selected_signal[i] : close_s2_ff[i];
      // single input feeds close through an inverter
      assign sc = c[`CFG_SINGLE] ? ~so : sc_raw;
      // one-hot: intermediate, open, close, bad
      assign st[i*4+0] = ~so & ~sc;
      assign st[i*4+1] = so & ~sc;
      assign st[i*4+2] = ~so & sc;
      assign st[i*4+3] = so & sc;
      // state code: bit 0 open level, bit 1 close level
      assign nxt_state[i*2] = so;
      assign nxt_state[i*2+1] = sc;
      // filter: on bit, then off bit per event
      assign keep[i*4+0] = st[i*4+0] ? c[`CFG_FILT_LSB+0] : c[`CFG_FILT_LSB+1];
      assign keep[i*4+1] = st[i*4+1] ? c[`CFG_FILT_LSB+2] : c[`CFG_FILT_LSB+3];
      assign keep[i*4+2] = st[i*4+2] ? c[`CFG_FILT_LSB+4] : c[`CFG_FILT_LSB+5];
      assign keep[i*4+3] = st[i*4+3] ? c[`CFG_FILT_LSB+6] : c[`CFG_FILT_LSB+7];
      assign inst_hit[i] = |set[i*4+3:i*4];
    end
  endgenerate

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  // each of the four signals changes on its own
  assign chg = st ^ prev_ff;
  // unselected edges are dropped here
  assign set = run_ff ? (chg & keep) : 40'h0000000000;

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      tick_cnt_ff <= 32'h00000000;
      ms_cnt_ff <= 32'h00000000;
    end else if (ce) begin
      // one tick per millisecond
      // count wraps silently at the top
      if (tick_cnt_ff == MS_CYCLES - 1) begin
        tick_cnt_ff <= 32'h00000000;
        ms_cnt_ff <= ms_cnt_ff + 32'h00000001;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // pending events and arbitration
  // ----------------------------------------
  always @* begin
    win = 6'h00;
    found = 1'b0;
    clr = 40'h0000000000;
    // scan downwards so the lowest slot wins
    for (k = 39; k >= 0; k = k - 1) begin
      if (pend_ff[k]) begin
        win = k[5:0];
        found = 1'b1;
      end
    end
    if (found) begin
      clr[win] = 1'b1;
    end
    if (run_ff) begin
      // a new edge wins over the clear of the same slot
      nxt_pend = (pend_ff & ~clr) | set;
    end else begin
      // stopped: the lowest pending slot still goes out on this edge, the rest is dropped
      nxt_pend = 40'h0000000000;
    end
  end

  // ----------------------------------------
  // edge, level and state registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      prev_ff <= 40'h0000000000;
      pend_ff <= 40'h0000000000;
      lvl_ff <= 40'h0000000000;
      state_ff <= 20'h00000;
    end else if (ce) begin
      prev_ff <= st;
      pend_ff <= nxt_pend;
      lvl_ff <= (lvl_ff & ~set) | (st & set);
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // time stamp capture
  // ----------------------------------------
  generate
    for (i = 0; i < `N_INST; i = i + 1) begin : g_stamp
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          stamp_ff[i] <= 32'h00000000;
        end else if (ce && inst_hit[i]) begin
          // stamp of the latest kept edge of the instance
          stamp_ff[i] <= ms_cnt_ff;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // event output
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ev_valid_ff <= 1'b0;
      ev_inst_ff <= 4'h0;
      ev_code_ff <= 2'h0;
      ev_on_ff <= 1'b0;
      ev_stamp_ff <= 32'h00000000;
    end else if (ce) begin
      // lowest pending slot goes out first
      ev_valid_ff <= found;
      if (found) begin
        ev_inst_ff <= win[5:2] + 4'h1;
        ev_code_ff <= win[1:0];
        // level at the latest kept edge
        ev_on_ff <= lvl_ff[win];
        ev_stamp_ff <= stamp_ff[win[5:2]];
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign cfg_off = addr - `ADDR_CFG_BASE;
  assign cfg_idx = cfg_off[5:2];
  assign cfg_hit = addr >= `ADDR_CFG_BASE && addr <= `ADDR_CFG_LAST && addr[1:0] == 2'h0;
  // settings frozen while monitoring runs
  assign cfg_wr = wr && !run_ff && cfg_hit;

  // ----------------------------------------
  // settings per instance
  // ----------------------------------------
  generate
    for (i = 0; i < `N_INST; i = i + 1) begin : g_cfg
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          cfg_ff[i] <= `CFG_RESET;
        end else if (ce && cfg_wr && cfg_idx == i) begin
          cfg_ff[i] <= wdata[11:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // run and mask
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      run_ff <= 1'b0;
      irq_mask_ff <= `IRQ_MASK_RESET;
    end else if (ce && wr) begin
      if (addr == `ADDR_CTRL) begin
        run_ff <= wdata[`CTRL_RUN];
      end
      if (addr == `ADDR_IRQ_MASK) begin
        irq_mask_ff <= wdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always @* begin
    irq_set = 3'h0;
    // an event leaves the block
    irq_set[`IRQ_EVENT] = found;
    // a kept on edge of the bad state
    irq_set[`IRQ_BAD] = |(set & {10{4'h8}} & st);
    // slot hit again while still pending
    irq_set[`IRQ_OVERRUN] = |(set & pend_ff & ~clr);
    rd_irq = rd && addr == `ADDR_IRQ_STAT;
  end

  // ----------------------------------------
  // interrupt line
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      // set wins over read clear
      irq_stat_ff <= (rd_irq ? 3'h0 : irq_stat_ff) | irq_set;
      irq_ff <= |(((rd_irq ? 3'h0 : irq_stat_ff) | irq_set) & irq_mask_ff);
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @* begin
    // unmapped addresses read zero
    nxt_rdata = 32'h00000000;
    if (addr == `ADDR_CTRL) begin
      nxt_rdata[`CTRL_RUN] = run_ff;
    end else if (addr == `ADDR_STATE) begin
      nxt_rdata[19:0] = state_ff;
    end else if (addr == `ADDR_IRQ_STAT) begin
      nxt_rdata[2:0] = irq_stat_ff;
    end else if (addr == `ADDR_IRQ_MASK) begin
      nxt_rdata[2:0] = irq_mask_ff;
    end else if (addr == `ADDR_TIME) begin
      nxt_rdata = ms_cnt_ff;
    end else if (cfg_hit) begin
      nxt_rdata[11:0] = cfg_ff[cfg_idx];
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      // data stand for one cycle only
      rdata <= rd ? nxt_rdata : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/contact_model.sv ====
// auxiliary contact model driving the monitor pins
`timescale 1ns/1ps
`default_nettype none
module contact_model (
  // position per instance: 0 travel, 1 open, 2 closed, 3 both
  input wire logic [19:0] pos,
  // instances fed from one contact
  input wire logic [9:0] single,
  // contact outputs
  output logic [9:0] open_pin,
  output logic [9:0] close_pin
);
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      open_pin[i] = pos[2*i];
      close_pin[i] = single[i] ? !pos[2*i] : pos[2*i+1];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ind_monitor_asserts.sv ====
// port checker for the indicator monitor
`timescale 1ns/1ps
`default_nettype none
module ind_monitor_chk #(
  parameter int MS_CYCLES = 10
) (
  // clock
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // bus
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // outputs
  input wire logic [19:0] state_ff,
  input wire logic ev_valid_ff,
  input wire logic [3:0] ev_inst_ff,
  input wire logic [1:0] ev_code_ff,
  input wire logic ev_on_ff,
  input wire logic [31:0] ev_stamp_ff,
  input wire logic irq_ff
);
  logic run_q;
  logic [2:0] mask_q;
  logic [11:0] cfg_q;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      run_q <= 1'h0;
      mask_q <= 3'h0;
      cfg_q <= 12'hFF0;
    end else if (ce && wr) begin
      if (addr == 8'h00) run_q <= wdata[0];
      if (addr == 8'h0C) mask_q <= wdata[2:0];
      if (addr == 8'h20 && !run_q) cfg_q <= wdata[11:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_inst_range: assert property (ev_valid_ff |-> ev_inst_ff >= 4'h1 && ev_inst_ff <= 4'hA)
    else $error("event instance out of range");
  a_fields_hold: assert property (!ev_valid_ff |-> $stable({ev_inst_ff, ev_code_ff, ev_on_ff}))
    else $error("event fields moved");
  a_rdata_idle: assert property ($past(ce) && !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside slot");
  a_state_read: assert property ($past(rd && addr == 8'h04) && $stable(state_ff) |-> rdata == {12'h0, state_ff})
    else $error("state read wrong");
  a_cfg_frozen: assert property ($past(rd && addr == 8'h20) |-> rdata == {20'h0, cfg_q})
    else $error("config read wrong");
  a_stop_quiet: assert property (!run_q && !$past(run_q) && !$past(run_q, 2) |-> !ev_valid_ff)
    else $error("event while stopped");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_ff)
    else $error("masked interrupt");
  a_irq_event: assert property (ev_valid_ff && mask_q[0] && !rd |-> ##[1:2] irq_ff)
    else $error("no interrupt on event");
  c_bad_on: cover property (ev_valid_ff && ev_on_ff && ev_code_ff == 2'h3);
  c_burst: cover property (ev_valid_ff ##1 ev_valid_ff);
  c_irq: cover property ($rose(irq_ff));
endmodule
bind ind_monitor ind_monitor_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .state_ff(state_ff), .ev_valid_ff(ev_valid_ff), .ev_inst_ff(ev_inst_ff),
  .ev_code_ff(ev_code_ff), .ev_on_ff(ev_on_ff), .ev_stamp_ff(ev_stamp_ff), .irq_ff(irq_ff));
`default_nettype wire

// ==== testbench/test_ind_monitor.sv ====
// self-checking bench for the indicator monitor
`timescale 1ns/1ps
`default_nettype none
module test_ind_monitor;
  localparam int MS = 10;
  typedef struct packed {logic [3:0] n; logic [1:0] c; logic on; logic [31:0] k;} ev_t;
  logic clk_sys = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, rd_d = 1'h0, run = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [9:0] uo = 10'h0, uc = 10'h0;
  logic [1:0] jk = 2'h0;
  logic [19:0] pos = 20'h0;
  logic [2:0] xs = 3'h0;
  logic [11:0] cfg [5] = '{12'hFF3, 12'hFF0, 12'hFF4, 12'h550, 12'hAA0};
  logic [31:0] rq [$];
  ev_t evq [$];
  ev_t x;
  int bs [16] = '{default: -1};
  int num_errors = 0, cmp_count = 0, ms = 0;
  wire [9:0] op, cp;
  wire [31:0] rdata, stamp;
  wire [19:0] state_ff;
  wire [3:0] inst;
  wire [1:0] code;
  wire ev_valid_ff, on, irq_ff;
  contact_model u_contacts (.pos({pos[19:2], jk}), .single(10'h004), .open_pin(op),
    .close_pin(cp));
  ind_monitor #(.MS_CYCLES(MS)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'h1),
    .open_pin(op), .close_pin(cp), .open_user_selected_signal(uo),
    .close_user_selected_signal(uc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .state_ff(state_ff), .ev_valid_ff(ev_valid_ff), .ev_inst_ff(inst),
    .ev_code_ff(code), .ev_on_ff(on), .ev_stamp_ff(stamp), .irq_ff(irq_ff));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_sys);
    wr <= 1'h0;
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys);
    rd <= 1'h0;
  endtask
  // decoded state, instance 3 fed from one contact
  function automatic logic [1:0] dec(input int i, input logic [1:0] p);
    return (i == 2) ? (p[0] ? 2'h1 : 2'h2) : p;
  endfunction
  function automatic logic [19:0] st_all();
    logic [19:0] s;
    for (int j = 0; j < 10; j++)
      s[2*j+:2] = dec(j, pos[2*j+:2]);
    return s;
  endfunction
  task move(input int i, input logic [1:0] p);
    logic [1:0] o, n;
    o = dec(i, pos[2*i+:2]);
    n = dec(i, p);
    for (int e = 0; e < 4; e++) begin
      if (run && (o == e) != (n == e) && cfg[i][4 + 2*e + (n != e)]) begin
        evq.push_back({4'(i + 1), 2'(e), n == e, 32'(ms)});
        xs |= {1'h0, e == 3 && n == e, 1'h1};
      end
    end
    pos[2*i+:2] <= p;
    jk <= 2'($urandom);
    uo <= {9'($urandom), i == 0 ? p[0] : pos[0]};
    uc <= {9'($urandom), i == 0 ? p[1] : pos[1]};
  endtask
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, rq.pop_front());
    if (ev_valid_ff) begin
      x = evq.pop_front();
      chk({inst, code, on}, {x.n, x.c, x.on});
      if (bs[x.n] < 0) bs[x.n] = stamp - x.k;
      chk(stamp - bs[x.n], x.k);
    end
  end
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    ms = $urandom(28);
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    chk({irq_ff, state_ff}, 32'h0);
    rreg(8'h0C, 32'h0);
    for (int j = 0; j < 10; j++)
      rreg(8'h20 + 8'(4 * j), 32'hFF0);
    for (int j = 0; j < 5; j++)
      wreg(8'h20 + 8'(4 * j), 32'(cfg[j]));
    wreg(8'h0C, 32'h3);
    wreg(8'h00, 32'h1);
    run = 1'h1;
    wreg(8'h20, 32'h0);
    rreg(8'h20, 32'hFF3);
    repeat (10) @(posedge clk_sys);
    chk(state_ff, st_all());
    for (int m = 0; m < 40; m++) begin
      ms = 2 * m;
      move($urandom % 5, 2'($urandom));
      repeat (2 * MS) @(posedge clk_sys);
      chk(state_ff, st_all());
    end
    chk(irq_ff, 1'h1);
    rreg(8'h08, 32'(xs));
    rreg(8'h08, 32'h0);
    rreg(8'h04, 32'(st_all()));
    rreg(8'h18, 32'h0);
    wreg(8'h00, 32'h0);
    run = 1'h0;
    move(0, ~pos[1:0]);
    repeat (20) @(posedge clk_sys);
    chk(irq_ff, 1'h0);
    chk(evq.size(), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
